// ===== cdc_pkg.sv
package cdc_pkg;

	// ************************************************************
	// controller states
	// ************************************************************
	typedef enum logic [2:0] {
		CDC_IDLE   = 3'h0,
		CDC_REF_P1 = 3'h1,
		CDC_REF_P2 = 3'h2,
		CDC_RD_P1  = 3'h3,
		CDC_RD_P2  = 3'h4,
		CDC_WR_P1  = 3'h5,
		CDC_WR_P2  = 3'h6
	} cdc_state_t;

	// ************************************************************
	// reset values and pin levels
	// ************************************************************
	localparam logic       CDC_PIN_ON        = 1'h0;
	localparam logic       CDC_PIN_OFF       = 1'h1;
	localparam logic       CDC_FLAG_RST      = 1'h0;
	localparam logic [1:0] CDC_SYNC_RST      = 2'h3;
	localparam logic [1:0] CDC_SYNC_PULSE_RST = 2'h0;

endpackage

// ===== cdc_cached_dram_ctrl.sv
module cdc_cached_dram_ctrl
	import cdc_pkg::*;
(
	// clock and reset
	input  wire logic clk,
	input  wire logic rstn,
	// processor bus pins
	input  wire logic proc_reset_n,
	input  wire logic timer_refresh_pulse,
	input  wire logic bus_strobe_n,
	input  wire logic write_sel_n,
	output logic      ready_n,
	// memory control pins
	output logic      row_enable_n,
	output logic      col_latch_n,
	output logic      write_strobe_n,
	output logic      output_gate_n,
	output logic      refresh_select_n,
	output logic      row_addr_select_n,
	output logic      col_addr_select_n
);

	// ************************************************************
	// reset release
	// ************************************************************
	logic [1:0] rst_sync_ff;
	logic       rst_n;

	// rstn may lift at any moment, so its release is re-timed before use
	// release only: assertion still acts at once through rstn
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			rst_sync_ff <= 2'h0;
		end else begin
			rst_sync_ff <= {rst_sync_ff[0], 1'h1};
		end
	end

	assign rst_n = rst_sync_ff[1];

	// ************************************************************
	// pin synchronisers
	// ************************************************************
	// trade-off: two cycles of latency on every pin buy metastability safety
	// sync chains idle at the pins' inactive levels so reset does not
	// fake a strobe; the pulse chain idles low
	logic [1:0] proc_reset_sync_ff;
	logic [1:0] strobe_sync_ff;
	logic [1:0] write_sel_sync_ff;
	logic [1:0] pulse_sync_ff;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			proc_reset_sync_ff <= CDC_SYNC_RST;
			strobe_sync_ff     <= CDC_SYNC_RST;
			write_sel_sync_ff  <= CDC_SYNC_RST;
			pulse_sync_ff      <= CDC_SYNC_PULSE_RST;
		end else begin
			proc_reset_sync_ff <= {proc_reset_sync_ff[0], proc_reset_n};
			strobe_sync_ff     <= {strobe_sync_ff[0], bus_strobe_n};
			write_sel_sync_ff  <= {write_sel_sync_ff[0], write_sel_n};
			pulse_sync_ff      <= {pulse_sync_ff[0], timer_refresh_pulse};
		end
	end

	// ************************************************************
	// asserted-level views of the inputs
	// ************************************************************
	logic proc_reset_on;
	logic strobe_on;
	logic write_on;
	logic refresh_pulse;

	assign proc_reset_on = (proc_reset_sync_ff[1] == CDC_PIN_ON);
	assign strobe_on     = (strobe_sync_ff[1] == CDC_PIN_ON);
	assign write_on      = (write_sel_sync_ff[1] == CDC_PIN_ON);
	assign refresh_pulse = pulse_sync_ff[1];

	// ************************************************************
	// state register
	// ************************************************************
	// three state bits; the one spare code is steered back to idle
	cdc_state_t state_ff;
	cdc_state_t nxt_state;
	logic       ref_pending_ff;
	logic       nxt_ref_pending;
	logic       refresh_due;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			state_ff <= CDC_IDLE;
		end else begin
			state_ff <= nxt_state;
		end
	end

	assign refresh_due = refresh_pulse | ref_pending_ff;

	// ************************************************************
	// next state
	// ************************************************************
	always_comb begin
		nxt_state = CDC_IDLE;
		unique case (state_ff)
			CDC_IDLE: begin
				// processor reset keeps refreshing the array continuously
				if (proc_reset_on) begin
					nxt_state = CDC_REF_P1;
				end else if (refresh_pulse) begin
					// pulse outranks strobe so a refresh never waits behind a burst
					nxt_state = CDC_REF_P1;
				end else if (strobe_on) begin
					nxt_state = write_on ? CDC_WR_P1 : CDC_RD_P1;
				end else begin
					nxt_state = CDC_IDLE;
				end
			end
			CDC_REF_P1: begin
				nxt_state = CDC_REF_P2;
			end
			CDC_REF_P2: begin
				nxt_state = CDC_IDLE;
			end
			CDC_RD_P1: begin
				nxt_state = CDC_RD_P2;
			end
			CDC_RD_P2: begin
				if (proc_reset_on) begin
					nxt_state = CDC_IDLE;
				end else if (refresh_due) begin
					nxt_state = CDC_REF_P1;
				end else if (strobe_on && !write_on) begin
					// back-to-back cache hits stay here with no wait state
					nxt_state = CDC_RD_P2;
				end else begin
					nxt_state = CDC_IDLE;
				end
			end
			CDC_WR_P1: begin
				nxt_state = CDC_WR_P2;
			end
			CDC_WR_P2: begin
				if (proc_reset_on) begin
					nxt_state = CDC_IDLE;
				end else if (refresh_due) begin
					nxt_state = CDC_REF_P1;
				end else if (!strobe_on && write_on) begin
					// kept as the original equations give it, strobe off
					nxt_state = CDC_WR_P1;
				end else if (strobe_on && !write_on) begin
					nxt_state = CDC_RD_P1;
				end else begin
					nxt_state = CDC_IDLE;
				end
			end
			default: begin
				// the eighth code is unused; recover to idle
				nxt_state = CDC_IDLE;
			end
		endcase
	end

	// ************************************************************
	// refresh request flag
	// ************************************************************
	// the flag follows the pulse during accesses so a request seen
	// mid-access survives into the access's last cycle
	always_comb begin
		unique case (state_ff)
			CDC_RD_P1, CDC_RD_P2, CDC_WR_P1, CDC_WR_P2: begin
				nxt_ref_pending = refresh_pulse;
			end
			CDC_IDLE: begin
				nxt_ref_pending = CDC_FLAG_RST;
			end
			CDC_REF_P1, CDC_REF_P2: begin
				// a pulse landing here is dropped: the refresh in flight covers it
				nxt_ref_pending = CDC_FLAG_RST;
			end
			default: begin
				nxt_ref_pending = CDC_FLAG_RST;
			end
		endcase
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			ref_pending_ff <= CDC_FLAG_RST;
		end else begin
			ref_pending_ff <= nxt_ref_pending;
		end
	end

	// ************************************************************
	// clock-gated outputs
	// ************************************************************
	// all but output gate and refresh select toggle inside a cycle by design: they follow the clock
	// level, so they are combinational from state, clk and the synced strobe and write pins
	// limitation: they may glitch at state changes; the memory must
	// tolerate that within its own timing margins
	logic clk_hi;
	logic clk_lo;
	logic ready_on;
	logic row_en_on;
	logic col_latch_on;
	logic write_on_out;
	logic gate_on;
	logic refresh_on;
	logic row_sel_on;
	logic col_sel_on;

	assign clk_hi = clk;
	assign clk_lo = ~clk;

	always_comb begin
		ready_on     = 1'h0;
		row_en_on    = 1'h0;
		col_latch_on = 1'h0;
		write_on_out = 1'h0;
		gate_on      = 1'h0;
		refresh_on   = 1'h0;
		row_sel_on   = 1'h0;
		col_sel_on   = 1'h0;
		unique case (state_ff)
			CDC_IDLE: begin
				// early ready lets a write finish with no wait state
				ready_on   = strobe_on & write_on;
				row_sel_on = 1'h1;
			end
			CDC_REF_P1: begin
				// both address selects stay off for the whole refresh
				refresh_on = 1'h1;
				row_en_on  = clk_lo;
			end
			CDC_REF_P2: begin
				row_en_on = clk_hi;
			end
			CDC_RD_P1: begin
				gate_on    = 1'h1;
				ready_on   = clk_lo;
				row_en_on  = clk_lo;
				row_sel_on = clk_hi;
				col_sel_on = clk_lo;
			end
			CDC_RD_P2: begin
				gate_on    = 1'h1;
				ready_on   = clk_lo;
				row_en_on  = clk_lo;
				col_sel_on = 1'h1;
			end
			CDC_WR_P1: begin
				row_en_on    = clk_lo;
				write_on_out = clk_lo;
				row_sel_on   = clk_hi;
				col_sel_on   = clk_lo;
			end
			CDC_WR_P2: begin
				// ready only while the processor still holds a write strobe
				ready_on     = strobe_on & write_on;
				row_en_on    = clk_hi;
				col_latch_on = clk_hi;
				write_on_out = clk_hi;
				col_sel_on   = 1'h1;
			end
			default: begin
				row_sel_on = 1'h1;
			end
		endcase
	end

	// ************************************************************
	// pin drivers
	// ************************************************************
	// every pin is active low; the on and off levels live in the package
	assign ready_n           = ready_on     ? CDC_PIN_ON : CDC_PIN_OFF;
	assign row_enable_n      = row_en_on    ? CDC_PIN_ON : CDC_PIN_OFF;
	assign col_latch_n       = col_latch_on ? CDC_PIN_ON : CDC_PIN_OFF;
	assign write_strobe_n    = write_on_out ? CDC_PIN_ON : CDC_PIN_OFF;
	assign output_gate_n     = gate_on      ? CDC_PIN_ON : CDC_PIN_OFF;
	assign refresh_select_n  = refresh_on   ? CDC_PIN_ON : CDC_PIN_OFF;
	assign row_addr_select_n = row_sel_on   ? CDC_PIN_ON : CDC_PIN_OFF;
	assign col_addr_select_n = col_sel_on   ? CDC_PIN_ON : CDC_PIN_OFF;

endmodule

// ===== cdc_ctrl_props.sv
module cdc_ctrl_props (
	// clock and reset
	input wire logic clk,
	input wire logic rstn,
	// processor side
	input wire logic proc_reset_n,
	input wire logic timer_refresh_pulse,
	input wire logic bus_strobe_n,
	input wire logic write_sel_n,
	input wire logic ready_n,
	// memory side
	input wire logic row_enable_n,
	input wire logic col_latch_n,
	input wire logic write_strobe_n,
	input wire logic output_gate_n,
	input wire logic refresh_select_n,
	input wire logic row_addr_select_n,
	input wire logic col_addr_select_n
);
	// ****
	// rising-edge samples see the low-half levels
	// ****
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rstn);
	sequence s_ref_two;
		refresh_select_n && ready_n && row_enable_n ##1 !row_addr_select_n;
	endsequence
	sequence s_wr_two;
		write_strobe_n && row_enable_n && !col_addr_select_n && output_gate_n;
	endsequence
	a_idle_quiet: assert property (!row_addr_select_n |-> refresh_select_n
		&& output_gate_n && write_strobe_n && row_enable_n && col_addr_select_n)
		else $error("idle pattern");
	a_ref_one: assert property (!refresh_select_n |-> ready_n && !row_enable_n
		&& row_addr_select_n && col_addr_select_n) else $error("refresh one");
	a_ref_high: assert property (@(negedge clk) !refresh_select_n |-> row_enable_n)
		else $error("refresh one high");
	a_ref_seq: assert property (!refresh_select_n |=> s_ref_two)
		else $error("refresh two");
	a_read_low: assert property (!output_gate_n |-> !ready_n && !row_enable_n
		&& !col_addr_select_n && row_addr_select_n) else $error("read low half");
	a_read_high: assert property (@(negedge clk) !output_gate_n |-> ready_n
		&& row_enable_n) else $error("read high half");
	a_write_seq: assert property (!write_strobe_n |-> ready_n && output_gate_n
		&& !row_enable_n ##1 s_wr_two) else $error("write steps");
	a_write_high: assert property (@(negedge clk) !write_strobe_n |-> !col_latch_n
		&& !row_enable_n) else $error("write two high");
endmodule

bind cdc_cached_dram_ctrl cdc_ctrl_props cdc_ctrl_props_i (.clk, .rstn, .proc_reset_n,
	.timer_refresh_pulse, .bus_strobe_n, .write_sel_n, .ready_n, .row_enable_n,
	.col_latch_n, .write_strobe_n, .output_gate_n, .refresh_select_n,
	.row_addr_select_n, .col_addr_select_n);

// ===== cdc_bus_model.sv
module cdc_bus_model (
	// clock
	input wire logic clk,
	// processor pins
	output logic     proc_reset_n,
	output logic     timer_refresh_pulse,
	output logic     bus_strobe_n,
	output logic     write_sel_n
);
	timeunit 1ns;
	timeprecision 1ps;
	initial begin
		proc_reset_n = 1'h1;
		timer_refresh_pulse = 1'h0;
		bus_strobe_n = 1'h1;
		write_sel_n = 1'h1;
	end
	// ****
	// pins held on for a count of cycles; the pulse lasts one cycle;
	// processor reset is held from cycle rs up to cycle nr
	// ****
	task automatic drive(input int ns, input int nw, input int pd, input int nr, input int rs);
		for (int c = 0; c < 24; c++) begin
			@(posedge clk);
			bus_strobe_n <= !(c < ns);
			write_sel_n <= !(c < nw);
			timer_refresh_pulse <= (c == pd);
			proc_reset_n <= !(c >= rs && c < nr);
		end
	endtask
endmodule

// ===== cdc_cached_dram_ctrl_tb_top.sv
module cdc_cached_dram_ctrl_tb_top
	import cdc_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk, rstn, proc_reset_n, timer_refresh_pulse, bus_strobe_n, write_sel_n;
	logic ready_n, row_enable_n, col_latch_n, write_strobe_n, output_gate_n;
	logic refresh_select_n, row_addr_select_n, col_addr_select_n;
	int   n_errors = 0;
	int   checked = 0;
	int   cycles = 0;
	cdc_cached_dram_ctrl cdc_cached_dram_ctrl_i (.clk, .rstn, .proc_reset_n,
		.timer_refresh_pulse, .bus_strobe_n, .write_sel_n, .ready_n, .row_enable_n,
		.col_latch_n, .write_strobe_n, .output_gate_n, .refresh_select_n,
		.row_addr_select_n, .col_addr_select_n);
	cdc_bus_model cdc_bus_model_i (.clk, .proc_reset_n, .timer_refresh_pulse,
		.bus_strobe_n, .write_sel_n);
	initial begin
		clk = 1'h0;
		forever #2 clk = ~clk;
	end
	always @(posedge clk) begin
		cycles++;
		if (cycles == 1000) begin
			n_errors++;
			conclude();
		end
	end
	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		checked++;
		if (seen !== exp) begin
			n_errors++;
			$display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic conclude();
		$display("errors %0d checks %0d", n_errors, checked);
		if (n_errors == 0 && checked > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	function automatic logic [7:0] pins();
		return {ready_n, row_enable_n, col_latch_n, write_strobe_n, output_gate_n,
			refresh_select_n, row_addr_select_n, col_addr_select_n};
	endfunction
	// ****
	// low-half counts: gate, write strobe, refresh select, ready
	// ****
	task automatic run(input int ns, nw, pd, nr, rs, eg, ew, er, ey);
		int g = 0, w = 0, r = 0, y = 0;
		fork
			cdc_bus_model_i.drive(ns, nw, pd, nr, rs);
			repeat (24) begin
				@(negedge clk);
				#1;
				g += int'(output_gate_n === CDC_PIN_ON);
				w += int'(write_strobe_n === CDC_PIN_ON);
				r += int'(refresh_select_n === CDC_PIN_ON);
				y += int'(ready_n === CDC_PIN_ON);
			end
		join
		// step off the launching edge before the idle pattern is read
		#1;
		check(8'(g), 8'(eg));
		check(8'(w), 8'(ew));
		check(8'(r), 8'(er));
		check(8'(y), 8'(ey));
		check(pins(), 8'hFD);
	endtask
	task automatic t_rd_miss();
		run(1, 0, -1, 0, 0, 2, 0, 0, 2);
	endtask
	task automatic t_rd_hit();
		run(4, 0, -1, 0, 0, 4, 0, 0, 4);
	endtask
	task automatic t_wr();
		run(1, 1, -1, 0, 0, 0, 1, 0, 1);
	endtask
	task automatic t_wr_loop();
		run(1, 4, -1, 0, 0, 0, 2, 0, 1);
	endtask
	task automatic t_wr_rd();
		run(3, 2, -1, 0, 0, 2, 1, 0, 3);
	endtask
	task automatic t_ref_idle();
		run(0, 0, 0, 0, 0, 0, 0, 1, 0);
	endtask
	task automatic t_ref_prio();
		run(3, 3, 0, 0, 0, 0, 0, 1, 1);
	endtask
	task automatic t_ref_rd();
		run(6, 0, 3, 0, 0, 3, 0, 1, 3);
	endtask
	task automatic t_ref_pend();
		run(4, 0, 1, 0, 0, 2, 0, 1, 2);
	endtask
	task automatic t_ref_wr();
		run(1, 1, 1, 0, 0, 0, 1, 1, 1);
	endtask
	task automatic t_proc_rst();
		run(0, 0, -1, 6, 0, 0, 0, 2, 0);
	endtask
	task automatic t_rst_rd();
		run(4, 0, -1, 4, 2, 2, 0, 1, 2);
	endtask
	task automatic t_rst_wr();
		run(1, 4, -1, 3, 2, 0, 1, 0, 1);
	endtask
	initial begin
		rstn = 1'h0;
		repeat (4) @(posedge clk);
		check(pins(), 8'hFD);
		rstn <= 1'h1;
		repeat (4) @(posedge clk);
		t_rd_miss();
		t_rd_hit();
		t_wr();
		t_wr_loop();
		t_wr_rd();
		t_ref_idle();
		t_ref_prio();
		t_ref_rd();
		t_ref_pend();
		t_ref_wr();
		t_proc_rst();
		t_rst_rd();
		t_rst_wr();
		conclude();
	end
endmodule
